/* File: hdl/ccg_map.svh */
`ifndef CCG_MAP_SVH
`define CCG_MAP_SVH

// register offsets (byte addresses)
`define CCG_PWRCTL_OFS 8'h00
`define CCG_STATUS_OFS 8'h04
`define CCG_DBGVAL_OFS 8'h08
// power control fields
`define CCG_EN_BIT 0
`define CCG_LAT_LSB 1
`define CCG_LAT_W 3
`define CCG_PWRCTL_RST 32'h0000_0000
`define CCG_DBGVAL_RST 32'h0000_0000
// status fields
`define CCG_ST_CORE_BIT 0
`define CCG_ST_CTRL_BIT 1
`define CCG_ST_VEC_BIT 2
`define CCG_ST_WAIT_LSB 3
`define CCG_ST_RST_LSB 6
// axi responses
`define CCG_RESP_OKAY 2'h0
`define CCG_RESP_SLVERR 2'h2
`endif

/* File: hdl/ccg_pkg.sv */
package ccg_pkg;
  typedef enum logic [1:0] {
    CCG_RUN = 2'b00,
    CCG_CUT = 2'b01,
    CCG_WAKE = 2'b10
  } ccg_gstate_t;
  typedef logic [2:0] ccg_lat_t;
endpackage

/* File: hdl/ccg_domain_gate.sv */
module ccg_domain_gate
  import ccg_pkg::*;
(
  input wire logic sysClk,
  input wire logic resetN,
  input wire logic clkEn,
  input wire logic gateEn,
  input wire logic idleCond,
  input wire logic clockStop,
  input wire ccg_pkg::ccg_lat_t latency,
  output logic gatedClk,
  output logic clkOn_r,
  output logic ready_r,
  output ccg_pkg::ccg_lat_t waitCnt_r
);
  ccg_gstate_t state_r;
  ccg_gstate_t state_nxt;
  logic enLatch;
  logic enable;

  // stop input wins over everything
  assign enable = !clockStop && (state_nxt != CCG_CUT);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CCG_RUN:
        if (gateEn && idleCond)
          state_nxt = CCG_CUT;
      CCG_CUT:
        if (!(gateEn && idleCond))
          state_nxt = CCG_WAKE;
      CCG_WAKE:
        if (waitCnt_r == '0)
          state_nxt = CCG_RUN;
      default:
        state_nxt = CCG_RUN;
    endcase
  end

  always_ff @(posedge sysClk or negedge resetN)
  begin
    if (!resetN)
      state_r <= CCG_RUN;
    else if (clkEn)
      state_r <= state_nxt;
  end

  // restart wait: senders hold off until count expires
  always_ff @(posedge sysClk or negedge resetN)
  begin
    if (!resetN)
      waitCnt_r <= '0;
    else if (clkEn)
    begin
      if (state_r == CCG_CUT && state_nxt == CCG_WAKE)
        waitCnt_r <= latency;
      else if (state_r == CCG_WAKE && waitCnt_r != '0)
        waitCnt_r <= waitCnt_r - 3'h1;
    end
  end

  always_ff @(posedge sysClk or negedge resetN)
  begin
    if (!resetN)
    begin
      clkOn_r <= 1'b1;
      ready_r <= 1'b1;
    end
    else if (clkEn)
    begin
      clkOn_r <= enable;
      ready_r <= enable && (state_nxt == CCG_RUN);
    end
  end

  // latch transparent while clock low, so no runt pulse
  always_latch
  begin
    if (!sysClk)
      enLatch <= enable;
  end

  assign gatedClk = sysClk & enLatch;
endmodule

/* File: hdl/ccg_clock_reset_ctrl.sv */
`include "ccg_map.svh"
module ccg_clock_reset_ctrl
  import ccg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic coreResetN,
  input wire logic debugLogicResetN,
  input wire logic vectorUnitResetN,
  input wire logic coreClockStop,
  input wire logic vectorUnitClockStop,
  input wire ccg_pkg::ccg_lat_t wakeLatencyConfig,
  input wire logic axiMasterClockEnable,
  input wire logic coreEmpty,
  input wire logic coreFull,
  input wire logic instLinefillMiss,
  input wire logic instTlbMiss,
  input wire logic dataLinefillMiss,
  input wire logic storeStallBuffersBusy,
  input wire logic sysInstExec,
  input wire logic sysInstInPipe,
  input wire logic perfEventsEnabled,
  input wire logic debugEnabled,
  input wire logic vectorInstInUnit,
  input wire logic vectorInstInPipe,
  input wire logic [31:0] axiOutNext,
  output logic [31:0] axiOut_r,
  output logic coreClk,
  output logic ctrlClk,
  output logic vectorClk,
  output logic coreReady_r,
  output logic ctrlReady_r,
  output logic vectorReady_r,
  output logic coreLogicResetN_r,
  output logic debugResetN_r,
  output logic vectorResetN_r,
  output logic [1:0] resetMode_r,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ccg_pkg::*;

  logic [31:0] pwrCtl_r;
  logic [31:0] dbgVal_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHave_r;
  logic wHave_r;
  logic gateEn;
  ccg_lat_t latency;
  logic coreIdle;
  logic ctrlIdle;
  logic vecIdle;
  logic coreOn;
  logic ctrlOn;
  logic vecOn;
  logic coreRdy;
  logic ctrlRdy;
  logic vecRdy;
  ccg_lat_t coreWait;
  ccg_lat_t ctrlWait;
  ccg_lat_t vecWait;
  logic doWrite;
  logic [2:0] rstSync [3];
  logic [2:0] rstRaw;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    return res;
  endfunction

  assign gateEn = pwrCtl_r[`CCG_EN_BIT];
  assign latency = pwrCtl_r[`CCG_LAT_LSB +: `CCG_LAT_W] | wakeLatencyConfig;

  // integer core cut cases
  assign coreIdle = (coreEmpty && (instLinefillMiss || instTlbMiss)) ||
                    (coreFull && (dataLinefillMiss || storeStallBuffersBusy));
  assign ctrlIdle = !sysInstExec && !sysInstInPipe && !perfEventsEnabled
                    && !debugEnabled;
  assign vecIdle = !vectorInstInUnit && !vectorInstInPipe;

  // three independent gates share one setting
  ccg_domain_gate u_core_gate (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .clkEn(clkEnable),
    .gateEn(gateEn),
    .idleCond(coreIdle),
    .clockStop(coreClockStop),
    .latency(latency),
    .gatedClk(coreClk),
    .clkOn_r(coreOn),
    .ready_r(coreRdy),
    .waitCnt_r(coreWait)
  );

  ccg_domain_gate u_ctrl_gate (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .clkEn(clkEnable),
    .gateEn(gateEn),
    .idleCond(ctrlIdle),
    .clockStop(coreClockStop),
    .latency(latency),
    .gatedClk(ctrlClk),
    .clkOn_r(ctrlOn),
    .ready_r(ctrlRdy),
    .waitCnt_r(ctrlWait)
  );

  ccg_domain_gate u_vec_gate (
    .sysClk(sys_clk),
    .resetN(reset_n),
    .clkEn(clkEnable),
    .gateEn(gateEn),
    .idleCond(vecIdle),
    .clockStop(vectorUnitClockStop),
    .latency(latency),
    .gatedClk(vectorClk),
    .clkOn_r(vecOn),
    .ready_r(vecRdy),
    .waitCnt_r(vecWait)
  );

  // ready outputs re-registered; all outputs but the gated clocks come from flops
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      coreReady_r <= 1'b1;
      ctrlReady_r <= 1'b1;
      vectorReady_r <= 1'b1;
    end
    else if (clkEnable)
    begin
      coreReady_r <= coreRdy;
      ctrlReady_r <= ctrlRdy;
      vectorReady_r <= vecRdy;
    end
  end

  // master outputs move only on enabled edges
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      axiOut_r <= 32'h0000_0000;
    else if (clkEnable && axiMasterClockEnable)
      axiOut_r <= axiOutNext;
  end

  // reset pins come from the controller: three flops, both assert and release
  // only once stages two and three agree
  assign rstRaw = {vectorUnitResetN, debugLogicResetN, coreResetN};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_rst
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
          rstSync[g] <= 3'b000;
        else if (clkEnable)
          rstSync[g] <= {rstSync[g][1:0], rstRaw[g]};
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      coreLogicResetN_r <= 1'b0;
      debugResetN_r <= 1'b0;
      vectorResetN_r <= 1'b0;
    end
    else if (clkEnable)
    begin
      if (rstSync[0][2] == rstSync[0][1])
        coreLogicResetN_r <= rstSync[0][2];
      if (rstSync[1][2] == rstSync[1][1])
        debugResetN_r <= rstSync[1][2];
      if (rstSync[2][2] == rstSync[2][1])
        vectorResetN_r <= rstSync[2][2];
    end
  end

  // 0 cold, 1 warm, 2 debug only, 3 run; other mixes report as run
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      resetMode_r <= 2'h0;
    else if (clkEnable)
      unique case ({coreLogicResetN_r, vectorResetN_r, debugResetN_r})
        3'b000: resetMode_r <= 2'h0;
        3'b001: resetMode_r <= 2'h1;
        3'b110: resetMode_r <= 2'h2;
        default: resetMode_r <= 2'h3;
      endcase
  end

  // axi-lite write path
  assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (clkEnable)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !awHave_r && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHave_r && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCG_RESP_OKAY;
    end
    else if (clkEnable)
    begin
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_r == `CCG_PWRCTL_OFS || awAddr_r == `CCG_DBGVAL_OFS) ?
                       `CCG_RESP_OKAY : `CCG_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // power control: cleared by the system reset and by core reset, so lost across warm reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pwrCtl_r <= `CCG_PWRCTL_RST;
    else if (clkEnable)
    begin
      if (!coreLogicResetN_r)
        pwrCtl_r <= `CCG_PWRCTL_RST;
      else if (doWrite && awAddr_r == `CCG_PWRCTL_OFS)
        pwrCtl_r <= mergeBytes(pwrCtl_r, wData_r, wStrb_r) & 32'h0000_000f;
    end
  end

  // debug value store stands for breakpoint state; only debug reset and the system reset clear it
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      dbgVal_r <= `CCG_DBGVAL_RST;
    else if (clkEnable)
    begin
      if (!debugResetN_r)
        dbgVal_r <= `CCG_DBGVAL_RST;
      else if (doWrite && awAddr_r == `CCG_DBGVAL_OFS)
        dbgVal_r <= mergeBytes(dbgVal_r, wData_r, wStrb_r);
    end
  end

  // axi-lite read path, one-cycle answer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCG_RESP_OKAY;
    end
    else if (clkEnable)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCG_RESP_OKAY;
        unique case (s_axi_araddr)
          `CCG_PWRCTL_OFS: s_axi_rdata <= pwrCtl_r;
          `CCG_STATUS_OFS: s_axi_rdata <= {23'h0, vectorResetN_r, debugResetN_r,
                                           coreLogicResetN_r, coreWait, vecOn, ctrlOn, coreOn};
          `CCG_DBGVAL_OFS: s_axi_rdata <= dbgVal_r;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCG_RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

/* File: verification/ccg_assertions.sv */
module ccg_assertions
  import ccg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic coreResetN,
  input wire logic debugLogicResetN,
  input wire logic vectorUnitResetN,
  input wire logic coreClockStop,
  input wire logic vectorUnitClockStop,
  input wire ccg_pkg::ccg_lat_t wakeLatencyConfig,
  input wire logic axiMasterClockEnable,
  input wire logic debugEnabled,
  input wire logic vectorInstInUnit,
  input wire logic vectorInstInPipe,
  input wire logic [31:0] axiOutNext,
  input wire logic [31:0] axiOut_r,
  input wire logic coreReady_r,
  input wire logic ctrlReady_r,
  input wire logic vectorReady_r,
  input wire logic vectorResetN_r,
  input wire logic [1:0] resetMode_r
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] pins;
  logic [1:0] expMode;
  assign pins = {coreResetN, vectorUnitResetN, debugLogicResetN};
  // mixes outside the table read as run
  assign expMode = pins == 3'h0 ? 2'h0 : pins == 3'h1 ? 2'h1 : pins == 3'h6 ? 2'h2 : 2'h3;
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  a_out_hold: assert property (!axiMasterClockEnable |=> $stable(axiOut_r))
    else $error("axi output moved");
  a_out_load: assert property (axiMasterClockEnable && clkEnable |=>
    axiOut_r == $past(axiOutNext)) else $error("axi output not loaded");
  a_reset_mode: assert property ((clkEnable && $stable(pins))[*6]
    |-> resetMode_r == expMode) else $error("reset mode wrong");
  a_vector_sync: assert property ((clkEnable && $stable(vectorUnitResetN))[*6]
    |-> vectorResetN_r == vectorUnitResetN) else $error("vector reset not followed");
  a_ctrl_busy: assert property (ctrlReady_r && debugEnabled && !coreClockStop
    |=> ctrlReady_r) else $error("busy control clock cut");
  a_vector_busy: assert property (vectorReady_r && (vectorInstInUnit || vectorInstInPipe)
    && !vectorUnitClockStop |=> vectorReady_r) else $error("busy vector clock cut");
  a_core_wake: assert property ($rose(coreReady_r) && wakeLatencyConfig == 3'h7
    |-> !$past(coreReady_r, 7)) else $error("core woke too early");
  a_vector_wake: assert property ($rose(vectorReady_r) && wakeLatencyConfig == 3'h7
    |-> !$past(vectorReady_r, 7)) else $error("vector woke too early");
endmodule

bind ccg_clock_reset_ctrl ccg_assertions chk_u (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .clkEnable(clkEnable),
  .coreResetN(coreResetN),
  .debugLogicResetN(debugLogicResetN),
  .vectorUnitResetN(vectorUnitResetN),
  .coreClockStop(coreClockStop),
  .vectorUnitClockStop(vectorUnitClockStop),
  .wakeLatencyConfig(wakeLatencyConfig),
  .axiMasterClockEnable(axiMasterClockEnable),
  .debugEnabled(debugEnabled),
  .vectorInstInUnit(vectorInstInUnit),
  .vectorInstInPipe(vectorInstInPipe),
  .axiOutNext(axiOutNext),
  .axiOut_r(axiOut_r),
  .coreReady_r(coreReady_r),
  .ctrlReady_r(ctrlReady_r),
  .vectorReady_r(vectorReady_r),
  .vectorResetN_r(vectorResetN_r),
  .resetMode_r(resetMode_r)
);

/* File: verification/ccg_soc_model.sv */
module ccg_soc_model
(
  input wire logic sys_clk,
  input wire logic rstReq,
  input wire logic [2:0] rstMode,
  output logic coreResetN,
  output logic vectorUnitResetN,
  output logic debugLogicResetN,
  output logic coreClockStop,
  output logic vectorUnitClockStop,
  output logic rstBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {coreResetN, vectorUnitResetN, debugLogicResetN} = 3'h7;
    {coreClockStop, vectorUnitClockStop, rstBusy} = 3'h0;
    forever
    begin
      @(posedge sys_clk);
      if (rstReq)
      begin
        // pins only move just after an edge
        rstBusy <= 1'b1;
        {coreResetN, vectorUnitResetN, debugLogicResetN} <= rstMode;
        // twelve cycles leaves margin over the minimum
        repeat (12) @(posedge sys_clk);
        {coreClockStop, vectorUnitClockStop} <= 2'h3;
        repeat (10) @(posedge sys_clk);
        {coreResetN, vectorUnitResetN, debugLogicResetN} <= 3'h7;
        repeat (10) @(posedge sys_clk);
        {coreClockStop, vectorUnitClockStop} <= 2'h0;
        rstBusy <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/ccg_clock_reset_ctrl_tb.sv */
`include "ccg_map.svh"
`define CHK(what, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module ccg_clock_reset_ctrl_tb;
  import ccg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, reset_n, clkEnable, coreResetN, debugLogicResetN, vectorUnitResetN;
  logic coreClockStop, vectorUnitClockStop, axiMasterClockEnable, coreEmpty, coreFull;
  logic instLinefillMiss, instTlbMiss, dataLinefillMiss, storeStallBuffersBusy, sysInstExec;
  logic sysInstInPipe, perfEventsEnabled, debugEnabled, vectorInstInUnit, vectorInstInPipe;
  logic coreClk, ctrlClk, vectorClk, coreReady_r, ctrlReady_r, vectorReady_r;
  logic coreLogicResetN_r, debugResetN_r, vectorResetN_r, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, rstReq, rstBusy;
  logic [1:0] resetMode_r, s_axi_bresp, s_axi_rresp, rsp, vecIn;
  logic [2:0] rstMode;
  logic [3:0] s_axi_wstrb, ctrlIn;
  logic [5:0] coreIn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] axiOutNext, axiOut_r, s_axi_wdata, s_axi_rdata, rd, expOut;
  logic [5:0] coreCase [4] = '{6'h28, 6'h24, 6'h12, 6'h11};
  ccg_lat_t wakeLatencyConfig;
  int mismatches, checksDone, n;
  wire [2:0] readyVec = {vectorReady_r, ctrlReady_r, coreReady_r};
  assign {coreEmpty, coreFull, instLinefillMiss, instTlbMiss} = coreIn[5:2];
  assign {dataLinefillMiss, storeStallBuffersBusy} = coreIn[1:0];
  assign {sysInstExec, sysInstInPipe, perfEventsEnabled, debugEnabled} = ctrlIn;
  assign {vectorInstInUnit, vectorInstInPipe} = vecIn;

  ccg_clock_reset_ctrl dut_u (.*);
  ccg_soc_model soc_u (.*);

  always #5 sys_clk = ~sys_clk;

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    stopTest();
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge sys_clk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && t < 60);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    if (t >= 60) hang();
  endtask

  task automatic axiRead(input logic [7:0] a);
    int t = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge sys_clk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && t < 60);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    if (t >= 60) hang();
  endtask

  task automatic waitReady(input int idx, input logic v, input string what);
    n = 0;
    while (readyVec[idx] !== v && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(what, v, readyVec[idx])
    if (n >= 60) stopTest();
  endtask

  task automatic doReset(input logic [2:0] m, input logic [1:0] e);
    int t = 0;
    @(posedge sys_clk);
    rstMode <= m;
    rstReq <= 1'b1;
    @(posedge sys_clk);
    rstReq <= 1'b0;
    repeat (9) @(posedge sys_clk);
    `CHK("reset mode", e, resetMode_r)
    while (rstBusy && t < 80)
    begin
      @(posedge sys_clk);
      t++;
    end
    if (rstBusy) hang();
    repeat (8) @(posedge sys_clk);
  endtask

  initial
  begin
    {sys_clk, reset_n, axiMasterClockEnable, rstReq, rstMode, coreIn, ctrlIn, vecIn} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, axiOutNext} = '0;
    clkEnable = 1'b1;
    s_axi_wstrb = 4'hf;
    wakeLatencyConfig = 3'h7;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    axiRead(`CCG_PWRCTL_OFS);
    `CHK("pwrctl reset", `CCG_PWRCTL_RST, rd)
    axiRead(`CCG_STATUS_OFS);
    `CHK("status idle", 32'h0000_01c7, rd)
    axiWrite(`CCG_PWRCTL_OFS, 32'h0000000f);
    axiRead(`CCG_PWRCTL_OFS);
    `CHK("pwrctl", 32'h0000000f, rd)
    axiWrite(8'h0c, 32'h00000001);
    `CHK("unmapped write", `CCG_RESP_SLVERR, rsp)
    axiRead(8'h0c);
    `CHK("unmapped read", `CCG_RESP_SLVERR, rsp)
    $display("registers done");
    expOut = 32'h0;
    for (int i = 0; i < 9; i++)
    begin
      axiMasterClockEnable <= (i % 3 == 0);
      axiOutNext <= 32'h10000000 + i;
      if (i % 3 == 0) expOut = 32'h10000000 + i;
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("axi out", expOut, axiOut_r)
      @(posedge sys_clk);
    end
    // clock enable low must freeze the master outputs too
    clkEnable <= 1'b0;
    axiMasterClockEnable <= 1'b1;
    axiOutNext <= 32'h2000_0000;
    repeat (3) @(posedge sys_clk);
    `CHK("axi out frozen", expOut, axiOut_r)
    clkEnable <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("axi out resumed", 32'h2000_0000, axiOut_r)
    @(posedge sys_clk);
    $display("master enable done");
    for (int k = 0; k < 4; k++)
    begin
      coreIn <= coreCase[k];
      waitReady(0, 1'b0, "core cut");
      coreIn <= 6'h0;
      waitReady(0, 1'b1, "core wake");
      `CHK("core wait", 1'b1, n >= 7)
    end
    waitReady(1, 1'b0, "ctrl idle");
    @(posedge sys_clk);
    #1;
    `CHK("ctrl clock cut", 1'b0, ctrlClk)
    for (int k = 0; k < 4; k++)
    begin
      ctrlIn <= 4'h1 << k;
      waitReady(1, 1'b1, "ctrl busy");
      ctrlIn <= 4'h0;
      waitReady(1, 1'b0, "ctrl idle");
    end
    waitReady(2, 1'b0, "vector idle");
    for (int k = 0; k < 2; k++)
    begin
      vecIn <= 2'h1 << k;
      waitReady(2, 1'b1, "vector busy");
      `CHK("vector wait", 1'b1, n >= 7)
      vecIn <= 2'h0;
      waitReady(2, 1'b0, "vector idle");
    end
    axiWrite(`CCG_PWRCTL_OFS, 32'h0);
    waitReady(2, 1'b1, "gating off");
    $display("gating done");
    axiWrite(`CCG_DBGVAL_OFS, 32'h0000a5a5);
    axiWrite(`CCG_PWRCTL_OFS, 32'h0000000f);
    doReset(3'h1, 2'h1);
    axiRead(`CCG_DBGVAL_OFS);
    `CHK("debug kept", 32'h0000a5a5, rd)
    axiRead(`CCG_PWRCTL_OFS);
    `CHK("pwrctl warm", 32'h0, rd)
    axiWrite(`CCG_PWRCTL_OFS, 32'h0000000f);
    doReset(3'h6, 2'h2);
    axiRead(`CCG_DBGVAL_OFS);
    `CHK("debug cleared", `CCG_DBGVAL_RST, rd)
    axiRead(`CCG_PWRCTL_OFS);
    `CHK("pwrctl kept", 32'h0000000f, rd)
    doReset(3'h0, 2'h0);
    axiRead(`CCG_PWRCTL_OFS);
    `CHK("pwrctl cold", 32'h0, rd)
    `CHK("run mode", 2'h3, resetMode_r)
    $display("resets done");
    stopTest();
  end
endmodule
